// ===== bench/core_model.sv
// processor core and wake manager as seen from the hub's lines
// assumes all lines are registered on mclk
`timescale 1ns/10ps
module core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic lineN,
  input wire logic fastN,
  input wire logic coreN,
  input wire logic coreF,
  input wire logic wake,
  output logic [7:0] takenN,
  output logic [7:0] takenF,
  output logic agree
);
  logic prevN, prevF;
  assign agree = (coreN === ~lineN) && (coreF === ~fastN) &&
    (wake === ~fastN);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prevN <= 1'b0;
      prevF <= 1'b0;
      takenN <= 8'h00;
      takenF <= 8'h00;
    end else begin
      prevN <= coreN;
      prevF <= coreF;
      if (coreN && !prevN)
        takenN <= takenN + 8'h01;
      if (coreF && !prevF)
        takenF <= takenF + 8'h01;
    end
  end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the interrupt hub over APB
// assumes the core model beside it and a short standby debounce
`timescale 1ns/10ps
module testbench;
  import interrupt_hub_pkg::*;
  localparam int DEB = 4;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [10:0] peripheralIrq = 11'h000;
  logic standbyPin = 0, pready, pslverr, irqPinOut, irqPinOe;
  logic lineN, fastN, coreN, coreF, wake, sw1, sw2, agree;
  logic [7:0] takenN, takenF;
  int err_count = 0, comparisons = 0;
  always #10 mclk = ~mclk;
  interrupt_hub #(.DEBOUNCE_LEN(DEB)) i_interrupt_hub (.mclk(mclk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .peripheralIrq(peripheralIrq),
    .standbyPin(standbyPin), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
    .normal_interrupt_line_n(lineN), .fast_interrupt_line_n(fastN),
    .coreNormalIrq(coreN), .coreFastIrq(coreF),
    .clock_wake_manager_wake(wake), .software_interrupt_one(sw1),
    .software_interrupt_two(sw2));
  core_model i_core_model (.mclk(mclk), .rst_n(rst_n), .lineN(lineN),
    .fastN(fastN), .coreN(coreN), .coreF(coreF), .wake(wake),
    .takenN(takenN), .takenF(takenF), .agree(agree));
  task close_out;
    $display("counts: mismatches %0d of %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {26'h0, a};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // ends once the slave raises pready; the watchdog catches a hang
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  function automatic logic [31:0] vecOf(input logic [31:0] s);
    for (int i = 1; i < 16; i++)
      if (s[i])
        return i;
    return 32'h0;
  endfunction
  // covers the standby sample flop, debounce and status flop
  task settle;
    repeat (DEB + 8) @(posedge mclk);
  endtask
  task setSrc(input int p, input logic v);
    if (p == POS_STANDBY)
      standbyPin <= v;
    else
      peripheralIrq[p - 1] <= v;
  endtask
  task chkSt(input logic [31:0] e, input logic [1:0] ln);
    logic [31:0] n, f;
    n = ln[0] ? e : 32'h0;
    f = ln[1] ? e : 32'h0;
    rdc(OFS_NORMAL_LINE_STATUS, n);
    rdc(OFS_FAST_LINE_STATUS, f);
    rdc(OFS_NORMAL_LINE_VECTOR, vecOf(n));
    rdc(OFS_FAST_LINE_VECTOR, vecOf(f));
    chk(lineN, n == 0);
    chk(fastN, f == 0);
    chk(agree, 1);
  endtask
  initial begin
    #1000000;
    err_count++;
    close_out;
  end
  initial begin
    int p, m;
    logic [1:0] ln;
    logic [31:0] b, r;
    logic e;
    void'($urandom(32'hc3df));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFS_OUTPUT_LEVELS, 32'h0);
    rdc(OFS_SOURCE_ENABLE, 32'h0);
    rdc(OFS_NORMAL_LINE_MASK, RESET_MASK_WORD);
    rdc(OFS_FAST_LINE_MASK, RESET_MASK_WORD);
    chkSt(32'h0, 2'b11);
    apb(1'b0, 6'h38, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1);
    $display("test reset done");
    peripheralIrq <= 11'h012;
    wr(OFS_NORMAL_LINE_MASK, 32'h0);
    settle;
    chkSt(32'h0, 2'b01);
    wr(OFS_SOURCE_ENABLE, 32'h24);
    settle;
    chkSt(32'h24, 2'b01);
    wr(OFS_STATUS_CLEAR, 32'h24);
    chkSt(32'h24, 2'b01);
    peripheralIrq <= 11'h013;
    wr(OFS_SOURCE_ENABLE, 32'h26);
    settle;
    chkSt(32'h26, 2'b01);
    peripheralIrq <= 11'h000;
    settle;
    wr(OFS_STATUS_CLEAR, 32'h26);
    wr(OFS_INPUT_INVERSION, 32'h8);
    wr(OFS_SOURCE_ENABLE, 32'h8);
    settle;
    chkSt(32'h8, 2'b01);
    rdc(OFS_INPUT_LEVELS, 32'h8);
    peripheralIrq <= 11'h004;
    settle;
    wr(OFS_STATUS_CLEAR, 32'h8);
    chkSt(32'h0, 2'b01);
    rdc(OFS_INPUT_LEVELS, 32'h0);
    $display("test level done");
    wr(OFS_INPUT_INVERSION, 32'hc001);
    wr(OFS_SIGNAL_DIRECTION, 32'hc001);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_OUTPUT_LEVELS, k ? 32'h8000 : 32'h4001);
      settle;
      chk({sw2, sw1}, k ? 2'b10 : 2'b01);
      chk({irqPinOe, irqPinOut}, k ? 2'b10 : 2'b11);
    end
    wr(OFS_INPUT_INVERSION, 32'h0);
    $display("test outputs done");
    for (int i = 0; i < 9; i++) begin
      m = 1 + i % 3;
      p = (i == 0) ? POS_STANDBY : 1 + $urandom % 11;
      ln = 1 + $urandom % 3;
      b = 32'h1 << p;
      wr(OFS_SOURCE_ENABLE, 32'h0);
      wr(OFS_NORMAL_LINE_MASK, 32'hffffffff);
      wr(OFS_FAST_LINE_MASK, 32'hffffffff);
      setSrc(p, 1'b0);
      settle;
      wr(OFS_DETECT_MODE_LOW, m[0] ? b : 32'h0);
      wr(OFS_DETECT_MODE_HIGH, m[1] ? b : 32'h0);
      wr(OFS_SOURCE_ENABLE, b);
      // also drops level bits latched by earlier tests
      wr(OFS_STATUS_CLEAR, 32'hffff);
      wr(OFS_NORMAL_LINE_MASK, ln[0] ? ~b : 32'hffffffff);
      wr(OFS_FAST_LINE_MASK, ln[1] ? ~b : 32'hffffffff);
      settle;
      chkSt(m[1] ? b : 32'h0, ln);
      wr(OFS_STATUS_CLEAR, b);
      setSrc(p, 1'b1);
      settle;
      chkSt(m[0] ? b : 32'h0, ln);
      wr(OFS_STATUS_CLEAR, b);
      setSrc(p, 1'b0);
      settle;
      chkSt(m[1] ? b : 32'h0, ln);
      wr(OFS_STATUS_CLEAR, b);
      chkSt(32'h0, ln);
    end
    $display("test edges done");
    chk(takenN != 0 && takenF != 0, 1);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFS_SOURCE_ENABLE, 32'h0);
    rdc(OFS_NORMAL_LINE_MASK, RESET_MASK_WORD);
    rdc(OFS_FAST_LINE_MASK, RESET_MASK_WORD);
    chkSt(32'h0, 2'b11);
    $display("test second reset done");
    close_out;
  end
endmodule

// ===== design/interrupt_hub.sv
// interrupt hub: 11 sources onto a normal and a fast active-low line
// assumes APB master on mclk; peripheral inputs synchronous to mclk
// Functional notes
// RL1: eleven inputs, each selectable for either line
// RL2: software sets direction; 15,14,0 are outputs
// RL3: input readback shows level after inversion
// RL4: outputs follow output register, ignore inversion
// RL5: level mode asserts while active level present
// RL6: level clear blocked while active and unmasked
// RL7: edge mode sets on chosen edge, inverted
// RL8: two mode bits: level, rise, fall, both
// RL9: status latches until written one to clear
// RL10: set status blocks new event registration
// RL11: edge enable sets status if already there
// RL12: software masks, configures, clears, then unmasks
// RL13: enable gates sources; reset clears enables
// RL14: normal line mask per input, resets set
// RL15: fast line mask per input, resets set
// RL16: status sets only if enabled and unmasked
// RL17: vector reports highest-priority pending per line
// RL18: lowest-numbered status bit wins priority
// RL19: line asserts while any status set
// RL20: lines active low, inverted core copies
// RL21: fast line also drives wake manager
// RL22: output bits 14 and 15 drive software interrupts
// RL23: standby input debounced before detection
// RL24: bit positions of the eleven inputs
// RL25: vector reads zero when nothing pending
`timescale 1ns/10ps
module interrupt_hub
  import interrupt_hub_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] peripheralIrq,
  input wire logic standbyPin,
  output logic irqPinOut,
  output logic irqPinOe,
  output logic normal_interrupt_line_n,
  output logic fast_interrupt_line_n,
  output logic coreNormalIrq,
  output logic coreFastIrq,
  output logic clock_wake_manager_wake,
  output logic software_interrupt_one,
  output logic software_interrupt_two
);
  if (DEBOUNCE_LEN < 1 || DEBOUNCE_LEN > 65535) begin
    $error("DEBOUNCE_LEN out of range");
  end

  logic [15:0] output_levels;
  logic [15:0] signal_direction;
  logic [15:0] input_inversion;
  logic [15:0] detect_mode_low;
  logic [15:0] detect_mode_high;
  logic [15:0] source_enable;
  logic [15:0] normal_line_mask;
  logic [15:0] fast_line_mask;
  logic [15:0] normal_line_status;
  logic [15:0] fast_line_status;
  logic [15:0] effLevel;
  logic [15:0] prevLevel;
  logic [15:0] clearHit;
  logic [15:0] normalHit;
  logic [15:0] fastHit;
  logic [15:0] prevNormalArm;
  logic [15:0] prevFastArm;
  logic [15:0] rawIn;
  logic [15:0] wantNormal;
  logic [15:0] wantFast;
  logic debSample;
  logic debState;
  logic [15:0] debCount;
  logic [15:0] next_normal;
  logic [15:0] next_fast;

  // lowest set bit index from bit 1 up, zero when bits 15..1 are empty
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = SIG_COUNT - 1; i >= 1; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  wire logic [5:0] ofs = paddr[5:0];
  wire logic mapped = (paddr[31:6] == 26'h0000000) && (ofs[1:0] == 2'h0)
      && (ofs <= OFS_FAST_LINE_STATUS);
  wire logic access = psel && penable;
  // unmapped writes must not alias onto the low offsets
  wire logic wrAccess = access && pwrite && pstrb[0] && pstrb[1] && mapped;

  // RL23: standby debounce
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      debSample <= 1'b0;
      debState <= 1'b0;
      debCount <= 16'h0000;
    end else begin
      debSample <= standbyPin;
      if (debSample == debState) begin
        debCount <= 16'h0000;
      end else if (debCount >= 16'(DEBOUNCE_LEN - 1)) begin
        debCount <= 16'h0000;
        debState <= debSample;
      end else begin
        debCount <= debCount + 16'h0001;
      end
    end
  end

  // RL24: bit positions of sources
  always_comb begin
    rawIn = 16'h0000;
    rawIn[11:1] = peripheralIrq;
    rawIn[POS_STANDBY] = debState;
  end

  // RL3: inversion on inputs only
  always_comb begin
    effLevel = (rawIn ^ input_inversion) & SOURCE_BITS & ~signal_direction;
  end

  // RL5: level and edge detection
  // RL7: edge sense follows inverted level
  // RL8: mode pairs decode
  // RL11: arming edge acts as level
  always_comb begin
    for (int i = 0; i < SIG_COUNT; i++) begin
      logic rise;
      logic fall;
      rise = effLevel[i] && (!prevLevel[i] || !prevNormalArm[i]);
      fall = !effLevel[i] && (prevLevel[i] || !prevNormalArm[i]);
      unique case ({detect_mode_high[i], detect_mode_low[i]})
        2'b00: normalHit[i] = effLevel[i];
        2'b01: normalHit[i] = rise;
        2'b10: normalHit[i] = fall;
        2'b11: normalHit[i] = rise || fall;
      endcase
      rise = effLevel[i] && (!prevLevel[i] || !prevFastArm[i]);
      fall = !effLevel[i] && (prevLevel[i] || !prevFastArm[i]);
      unique case ({detect_mode_high[i], detect_mode_low[i]})
        2'b00: fastHit[i] = effLevel[i];
        2'b01: fastHit[i] = rise;
        2'b10: fastHit[i] = fall;
        2'b11: fastHit[i] = rise || fall;
      endcase
      // RL16: gated by enable and line mask
      normalHit[i] = normalHit[i] && wantNormal[i];
      fastHit[i] = fastHit[i] && wantFast[i];
    end
  end

  // RL1: any source to either line
  // RL13: enable gates
  // RL14: normal mask
  // RL15: fast mask
  always_comb begin
    wantNormal = source_enable & ~normal_line_mask & SOURCE_BITS;
    wantFast = source_enable & ~fast_line_mask & SOURCE_BITS;
  end

  always_comb begin
    clearHit = 16'h0000;
    if (wrAccess && ofs == OFS_STATUS_CLEAR) begin
      clearHit = pwdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prevLevel <= RESET_ZERO;
      prevNormalArm <= RESET_ZERO;
      prevFastArm <= RESET_ZERO;
    end else begin
      prevLevel <= effLevel;
      prevNormalArm <= wantNormal;
      prevFastArm <= wantFast;
    end
  end

  // RL9: latch until cleared
  // RL6: active level keeps bit
  // RL10: set bit absorbs events
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      normal_line_status <= RESET_ZERO;
      fast_line_status <= RESET_ZERO;
    end else begin
      normal_line_status <= (normal_line_status & ~clearHit) | normalHit;
      fast_line_status <= (fast_line_status & ~clearHit) | fastHit;
    end
  end

  // register writes; reserved bits kept zero except masks
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      output_levels <= RESET_ZERO;
      signal_direction <= RESET_ZERO;
      input_inversion <= RESET_ZERO;
      detect_mode_low <= RESET_ZERO;
      detect_mode_high <= RESET_ZERO;
      source_enable <= RESET_ZERO;
      normal_line_mask <= RESET_MASK;
      fast_line_mask <= RESET_MASK;
    end else if (wrAccess) begin
      unique case (ofs)
        OFS_OUTPUT_LEVELS: output_levels <= pwdata[15:0];
        OFS_SIGNAL_DIRECTION: signal_direction <= pwdata[15:0];
        OFS_INPUT_INVERSION: input_inversion <= pwdata[15:0];
        OFS_DETECT_MODE_LOW: detect_mode_low <= pwdata[15:0];
        OFS_DETECT_MODE_HIGH: detect_mode_high <= pwdata[15:0];
        OFS_SOURCE_ENABLE: source_enable <= pwdata[15:0];
        OFS_NORMAL_LINE_MASK: normal_line_mask <= pwdata[15:0];
        OFS_FAST_LINE_MASK: fast_line_mask <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // zero-wait slave: ready during every access
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite && mapped) begin
        unique case (ofs)
          OFS_OUTPUT_LEVELS: prdata <= {16'h0000, output_levels};
          OFS_INPUT_LEVELS: prdata <= {16'h0000, effLevel};
          OFS_SIGNAL_DIRECTION: prdata <= {16'h0000, signal_direction};
          OFS_INPUT_INVERSION: prdata <= {16'h0000, input_inversion};
          OFS_DETECT_MODE_LOW: prdata <= {16'h0000, detect_mode_low};
          OFS_DETECT_MODE_HIGH: prdata <= {16'h0000, detect_mode_high};
          OFS_SOURCE_ENABLE: prdata <= {16'h0000, source_enable};
          OFS_NORMAL_LINE_MASK: prdata <= {16'hffff, normal_line_mask};
          // RL17: vector readback
          // RL18: lowest bit wins
          // RL25: zero when empty
          OFS_NORMAL_LINE_VECTOR:
            prdata <= {27'h0000000, first_set(normal_line_status)};
          OFS_NORMAL_LINE_STATUS: prdata <= {16'h0000, normal_line_status};
          OFS_FAST_LINE_MASK: prdata <= {16'hffff, fast_line_mask};
          OFS_FAST_LINE_VECTOR:
            prdata <= {27'h0000000, first_set(fast_line_status)};
          OFS_FAST_LINE_STATUS: prdata <= {16'h0000, fast_line_status};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // RL19: any status asserts line
  // RL20: active low, inverted core copies
  // RL21: fast line to wake manager
  // RL4: outputs from output register
  // RL22: software interrupt bits
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      normal_interrupt_line_n <= 1'b1;
      fast_interrupt_line_n <= 1'b1;
      coreNormalIrq <= 1'b0;
      coreFastIrq <= 1'b0;
      clock_wake_manager_wake <= 1'b0;
      software_interrupt_one <= 1'b0;
      software_interrupt_two <= 1'b0;
      irqPinOut <= 1'b0;
      irqPinOe <= 1'b0;
    end else begin
      normal_interrupt_line_n <= ~(|next_normal);
      fast_interrupt_line_n <= ~(|next_fast);
      coreNormalIrq <= |next_normal;
      coreFastIrq <= |next_fast;
      clock_wake_manager_wake <= |next_fast;
      software_interrupt_one <= output_levels[POS_SWI_ONE]
          && signal_direction[POS_SWI_ONE];
      software_interrupt_two <= output_levels[POS_SWI_TWO]
          && signal_direction[POS_SWI_TWO];
      irqPinOut <= output_levels[POS_PIN];
      irqPinOe <= signal_direction[POS_PIN];
    end
  end

  always_comb begin
    next_normal = (normal_line_status & ~clearHit) | normalHit;
    next_fast = (fast_line_status & ~clearHit) | fastHit;
  end
  // RL9: bit stays until cleared
  property p_status_hold;
    @(posedge mclk) disable iff (!rst_n)
      (normal_line_status[POS_GPIO] && !clearHit[POS_GPIO])
      |=> normal_line_status[POS_GPIO];
  endproperty
  a_status_hold: assert property (p_status_hold) // RL9
    else $error("status bit dropped without clear");
  property p_level_keep;
    @(posedge mclk) disable iff (!rst_n)
      (detect_mode_low[POS_GPIO] == 1'b0 && detect_mode_high[POS_GPIO] == 1'b0
       && wantNormal[POS_GPIO] && effLevel[POS_GPIO])
      |=> normal_line_status[POS_GPIO];
  endproperty
  a_level_keep: assert property (p_level_keep) // RL6
    else $error("level status cleared while active");
  property p_gate;
    @(posedge mclk) disable iff (!rst_n)
      (!wantFast[POS_GPIO] && !fast_line_status[POS_GPIO])
      |=> !fast_line_status[POS_GPIO];
  endproperty
  a_gate: assert property (p_gate) // RL16
    else $error("fast status set while gated");
  property p_line;
    @(posedge mclk) disable iff (!rst_n)
      (|normal_line_status) |-> !normal_interrupt_line_n;
  endproperty
  a_line: assert property (p_line) // RL19
    else $error("normal line idle with status set");
  property p_core;
    @(posedge mclk) disable iff (!rst_n)
      coreFastIrq == !fast_interrupt_line_n;
  endproperty
  a_core: assert property (p_core) // RL20
    else $error("core copy not inverse of line");
  property p_wake;
    @(posedge mclk) disable iff (!rst_n)
      clock_wake_manager_wake == coreFastIrq;
  endproperty
  a_wake: assert property (p_wake) // RL21
    else $error("wake output differs from fast line");
  property p_swi;
    @(posedge mclk) disable iff (!rst_n)
      $rose(output_levels[POS_SWI_ONE]) && signal_direction[POS_SWI_ONE]
      && $stable(signal_direction) |=> software_interrupt_one;
  endproperty
  a_swi: assert property (p_swi) // RL22
    else $error("software interrupt one not driven");
  property p_rise;
    @(posedge mclk) disable iff (!rst_n)
      (detect_mode_low[POS_GPIO] && !detect_mode_high[POS_GPIO]
       && wantNormal[POS_GPIO] && prevNormalArm[POS_GPIO]
       && $rose(effLevel[POS_GPIO])) |=> normal_line_status[POS_GPIO];
  endproperty
  a_rise: assert property (p_rise) // RL7
    else $error("rising edge missed");
  property p_reset_mask;
    @(posedge mclk) $fell(rst_n) |=> normal_line_mask == RESET_MASK
      && fast_line_mask == RESET_MASK && source_enable == RESET_ZERO;
  endproperty
  a_reset_mask: assert property (p_reset_mask) // RL13
    else $error("reset values wrong");
endmodule

// ===== design/interrupt_hub_pkg.sv
// constants for the dual-line interrupt hub: map, fields, resets
// assumes an APB slave with 32-bit data, byte addresses
package interrupt_hub_pkg;
  localparam int unsigned SIG_COUNT = 16;
  localparam logic [5:0] OFS_OUTPUT_LEVELS = 6'h00;
  localparam logic [5:0] OFS_INPUT_LEVELS = 6'h04;
  localparam logic [5:0] OFS_SIGNAL_DIRECTION = 6'h08;
  localparam logic [5:0] OFS_INPUT_INVERSION = 6'h0c;
  localparam logic [5:0] OFS_DETECT_MODE_LOW = 6'h10;
  localparam logic [5:0] OFS_DETECT_MODE_HIGH = 6'h14;
  localparam logic [5:0] OFS_SOURCE_ENABLE = 6'h18;
  localparam logic [5:0] OFS_STATUS_CLEAR = 6'h1c;
  localparam logic [5:0] OFS_NORMAL_LINE_MASK = 6'h20;
  localparam logic [5:0] OFS_NORMAL_LINE_VECTOR = 6'h24;
  localparam logic [5:0] OFS_NORMAL_LINE_STATUS = 6'h28;
  localparam logic [5:0] OFS_FAST_LINE_MASK = 6'h2c;
  localparam logic [5:0] OFS_FAST_LINE_VECTOR = 6'h30;
  localparam logic [5:0] OFS_FAST_LINE_STATUS = 6'h34;
  // signal positions
  localparam int unsigned POS_PIN = 0;
  localparam int unsigned POS_GPIO = 1;
  localparam int unsigned POS_STANDBY = 7;
  localparam int unsigned POS_SWI_ONE = 14;
  localparam int unsigned POS_SWI_TWO = 15;
  // inputs that can interrupt: bits 11..1
  localparam logic [15:0] SOURCE_BITS = 16'h0ffe;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [15:0] RESET_MASK = 16'hffff;
  localparam logic [31:0] RESET_MASK_WORD = 32'hffffffff;
  // standby debounce
  localparam int unsigned CLOCK_HZ = 50000000;
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLOCK_HZ / 1000000);
endpackage
